// >>> core/pss_selector.sv
`timescale 1ns/1ns
// Behaviour
// R1 - Four select bits form binary code n choosing stored setpoint n.
// R2 - Code zero uses base setpoint from setpoint-zero or main parameter.
// R3 - Five programmable inputs; any four may carry the select functions.
// R4 - Software assigns each input's function through its own parameter; here all five share one word at 8'h04.
// R5 - Only the low select bits in use need wiring.
// R6 - With scaling, software writes setpoints in scaled process units.
// R7 - PID enable value 01 runs process control; may be written first.
// R8 - Regulation value 02 suspends voltage regulation only while decelerating.
// R9 - Regulation value 01 switches voltage regulation off.
// R10 - Feedback source 00 takes the actual value from the current input.
// R11 - Feedback source 01 takes the actual value from the voltage input.
// R12 - Direct action raises frequency below setpoint, lowers it above.
// R13 - Lower threshold 100 and upper 0 give reverse action.
// R14 - Setpoint and actual value never share one analogue input.
// R15 - A changed select code re-selects the setpoint for the next update.
`include "pss_params.svh"

module pss_selector
  import pss_pkg::*;
#(
  parameter int SP_W = 16,
  parameter int NUM_IN = 5
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] digital_in,
  input wire logic motor_decel,
  input wire logic [SP_W-1:0] analog_current_input,
  input wire logic [SP_W-1:0] analog_voltage_input,
  output logic [SP_W-1:0] active_setpoint,
  output logic [SP_W-1:0] process_feedback,
  output logic pid_active,
  output logic avr_enable,
  output logic freq_raise,
  output logic freq_lower
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  if (SP_W < 8 || SP_W > 32 || NUM_IN != 5)
  begin : g_bad_param
    $error("pss_selector: unsupported SP_W or NUM_IN");
  end

  // ************************************************************
  // Registers
  // ************************************************************
  pss_ctrl_t ctrl;
  pss_func_t in_func [NUM_IN];
  logic [6:0] feedback_lower_threshold_pct;
  logic [6:0] feedback_upper_threshold_pct;
  logic [SP_W-1:0] setpoint_zero_param;
  logic [SP_W-1:0] main_setpoint_param;
  logic [SP_W-1:0] stored_setpoint [1:15];
  logic [3:0] code;
  logic reverse;
  logic [3:0] next_code;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_en;
  pss_status_t status;

  function automatic logic is_table(input logic [7:0] a);
    is_table = (a[7:6] == `PSS_TABLE_TAG) && (a[5:2] != 4'h0) && (a[1:0] == 2'h0);
  endfunction : is_table
  function automatic logic [31:0] zext(input logic [SP_W-1:0] v);
    zext = 32'(v);
  endfunction : zext

  // ************************************************************
  // APB slave
  // ************************************************************
  assign wr_en = psel && penable && pready && pwrite;

  always_comb
  begin
    status = '{fb_src: ctrl.fb_src, reverse: reverse, avr_on: avr_enable,
               pid_on: pid_active, code: code};
    rd_ok = 1'b1;
    rd_data = 32'h0;
    case (paddr)
      `PSS_ADDR_CTRL: rd_data = 32'(ctrl);
      `PSS_ADDR_INFUNC:
        for (int i = 0; i < NUM_IN; i++)
        begin
          rd_data[i*`PSS_FN_W +: `PSS_FN_W] = in_func[i];
        end
      `PSS_ADDR_THRESH:
      begin
        rd_data[`PSS_THR_LO_LSB +: 7] = feedback_lower_threshold_pct;
        rd_data[`PSS_THR_HI_LSB +: 7] = feedback_upper_threshold_pct;
      end
      `PSS_ADDR_SPZERO: rd_data = zext(setpoint_zero_param);
      `PSS_ADDR_SPMAIN: rd_data = zext(main_setpoint_param);
      `PSS_ADDR_STATUS: rd_data = 32'(status);
      `PSS_ADDR_ACTIVE: rd_data = zext(active_setpoint);
      default:
        if (is_table(paddr))
        begin
          rd_data = zext(stored_setpoint[paddr[5:2]]);
        end
        else
        begin
          rd_ok = 1'b0;
        end
    endcase
  end

  // One wait state, answer registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata <= (pwrite || !rd_ok) ? 32'h0 : rd_data;
        pslverr <= !rd_ok;
      end
    end
  end

  // Configuration writes; status and active words are read-only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= pss_ctrl_t'(`PSS_CTRL_RESET);
      for (int i = 0; i < NUM_IN; i++)
      begin
        in_func[i] <= PSS_FN_NONE;
      end
      feedback_lower_threshold_pct <= `PSS_THR_LO_RESET;
      feedback_upper_threshold_pct <= `PSS_THR_HI_RESET;
      setpoint_zero_param <= '0;
      main_setpoint_param <= '0;
      for (int n = 1; n < 16; n++)
      begin
        stored_setpoint[n] <= '0;
      end
    end
    else if (wr_en)
    begin
      case (paddr)
        `PSS_ADDR_CTRL: ctrl <= pss_ctrl_t'(pwdata[6:0]); // R7
        `PSS_ADDR_INFUNC:
          for (int i = 0; i < NUM_IN; i++)
          begin
            in_func[i] <= pss_func_t'(pwdata[i*`PSS_FN_W +: `PSS_FN_W]);
          end
        `PSS_ADDR_THRESH:
        begin
          feedback_lower_threshold_pct <= pwdata[`PSS_THR_LO_LSB +: 7];
          feedback_upper_threshold_pct <= pwdata[`PSS_THR_HI_LSB +: 7];
        end
        `PSS_ADDR_SPZERO: setpoint_zero_param <= pwdata[SP_W-1:0];
        `PSS_ADDR_SPMAIN: main_setpoint_param <= pwdata[SP_W-1:0];
        default:
          if (is_table(paddr))
          begin
            stored_setpoint[paddr[5:2]] <= pwdata[SP_W-1:0];
          end
      endcase
    end
  end

  // ************************************************************
  // Select code from programmable inputs
  // ************************************************************
  always_comb
  begin
    next_code = 4'h0;
    for (int i = 0; i < NUM_IN; i++)
    begin
      case (in_func[i])
        PSS_FN_SEL0: next_code[0] = next_code[0] | digital_in[i]; // R3
        PSS_FN_SEL1: next_code[1] = next_code[1] | digital_in[i];
        PSS_FN_SEL2: next_code[2] = next_code[2] | digital_in[i];
        PSS_FN_SEL3: next_code[3] = next_code[3] | digital_in[i];
        default: next_code = next_code;
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      code <= 4'h0;
    end
    else
    begin
      code <= next_code; // R15
    end
  end

  // ************************************************************
  // Setpoint and feedback selection
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_setpoint <= '0;
    end
    else if (code == 4'h0)
    begin
      active_setpoint <= ctrl.base_sel ? main_setpoint_param : setpoint_zero_param; // R2
    end
    else
    begin
      active_setpoint <= stored_setpoint[code]; // R1
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      process_feedback <= '0;
    end
    else if (ctrl.fb_src == `PSS_FB_VOLTAGE)
    begin
      process_feedback <= analog_voltage_input; // R11
    end
    else
    begin
      process_feedback <= analog_current_input; // R10
    end
  end

  // ************************************************************
  // Mode, voltage regulation and control action
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pid_active <= 1'b0;
      avr_enable <= 1'b1;
      reverse <= 1'b0;
    end
    else
    begin
      pid_active <= (ctrl.pid_en == `PSS_PID_ON); // R7
      case (ctrl.avr)
        `PSS_AVR_OFF: avr_enable <= 1'b0; // R9
        `PSS_AVR_NODECEL: avr_enable <= !motor_decel; // R8
        default: avr_enable <= 1'b1;
      endcase
      reverse <= (feedback_lower_threshold_pct == `PSS_REV_LO) &&
                 (feedback_upper_threshold_pct == `PSS_REV_HI); // R13
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst || !pid_active)
    begin
      freq_raise <= 1'b0;
      freq_lower <= 1'b0;
    end
    else if (reverse)
    begin
      freq_raise <= process_feedback > active_setpoint; // R13
      freq_lower <= process_feedback < active_setpoint;
    end
    else
    begin
      freq_raise <= process_feedback < active_setpoint; // R12
      freq_lower <= process_feedback > active_setpoint;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_STORED_SEL: assert property (@(posedge clk) disable iff (rst) // R1
    code != 4'h0 |=> active_setpoint == $past(stored_setpoint[code]))
    else $error("stored setpoint not selected by code");

  AST_BASE_SEL: assert property (@(posedge clk) disable iff (rst) // R2
    code == 4'h0 && ctrl.base_sel |=> active_setpoint == $past(main_setpoint_param))
    else $error("base setpoint not selected for code zero");

  AST_INPUT_MAP: assert property (@(posedge clk) disable iff (rst) // R3
    in_func[4] == PSS_FN_SEL3 && digital_in[4] |=> code[3])
    else $error("input five not mapped onto select bit three");

  AST_RESELECT: assert property (@(posedge clk) disable iff (rst) // R15
    next_code != code ##1 next_code == code |=> active_setpoint ==
      $past(code == 4'h0 ? active_setpoint : stored_setpoint[code]) || code == 4'h0)
    else $error("setpoint not reselected after code change");

  AST_PID_MODE: assert property (@(posedge clk) disable iff (rst) // R7
    ctrl.pid_en != `PSS_PID_ON |=> !pid_active ##1 !(freq_raise || freq_lower))
    else $error("control action outside process mode");

  AST_AVR_DECEL: assert property (@(posedge clk) disable iff (rst) // R8
    ctrl.avr == `PSS_AVR_NODECEL |=> avr_enable == !$past(motor_decel))
    else $error("regulation not suspended only in deceleration");

  AST_AVR_OFF: assert property (@(posedge clk) disable iff (rst) // R9
    ctrl.avr == `PSS_AVR_OFF |=> !avr_enable)
    else $error("regulation still on with setting off");

  AST_FB_CURRENT: assert property (@(posedge clk) disable iff (rst) // R10
    ctrl.fb_src == `PSS_FB_CURRENT |=> process_feedback == $past(analog_current_input))
    else $error("feedback not from current input");

  AST_FB_VOLTAGE: assert property (@(posedge clk) disable iff (rst) // R11
    ctrl.fb_src == `PSS_FB_VOLTAGE |=> process_feedback == $past(analog_voltage_input))
    else $error("feedback not from voltage input");

  AST_DIRECT: assert property (@(posedge clk) disable iff (rst) // R12
    pid_active && !reverse && process_feedback < active_setpoint |=> freq_raise && !freq_lower)
    else $error("direct action did not raise frequency");

  AST_REVERSE: assert property (@(posedge clk) disable iff (rst) // R13
    feedback_lower_threshold_pct == `PSS_REV_LO && feedback_upper_threshold_pct ==
      `PSS_REV_HI |=> reverse)
    else $error("reverse action not taken from thresholds");

endmodule : pss_selector

// >>> core/pss_params.svh
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH
// Register byte offsets
`define PSS_ADDR_CTRL 8'h00
`define PSS_ADDR_INFUNC 8'h04
`define PSS_ADDR_THRESH 8'h08
`define PSS_ADDR_SPZERO 8'h0c
`define PSS_ADDR_SPMAIN 8'h10
`define PSS_ADDR_STATUS 8'h14
`define PSS_ADDR_ACTIVE 8'h18
// Stored setpoints n = 1..15 at 8'h40 + 4*n
`define PSS_TABLE_TAG 2'h1
// Field positions
`define PSS_THR_LO_LSB 0
`define PSS_THR_HI_LSB 8
`define PSS_FN_W 3
// Reset values
`define PSS_CTRL_RESET 7'h08
`define PSS_INFUNC_RESET 15'h0000
`define PSS_THR_LO_RESET 7'h00
`define PSS_THR_HI_RESET 7'h64
// Mode encodings
`define PSS_PID_ON 2'h1
`define PSS_AVR_ALWAYS 2'h0
`define PSS_AVR_OFF 2'h1
`define PSS_AVR_NODECEL 2'h2
`define PSS_FB_CURRENT 2'h0
`define PSS_FB_VOLTAGE 2'h1
`define PSS_REV_LO 7'h64
`define PSS_REV_HI 7'h00
`endif

// >>> core/pss_pkg.sv
package pss_pkg;

  // Control register layout
  typedef struct packed {
    logic base_sel;
    logic [1:0] fb_src;
    logic [1:0] avr;
    logic [1:0] pid_en;
  } pss_ctrl_t;

  // Function carried by one digital input
  typedef enum logic [2:0] {
    PSS_FN_NONE,
    PSS_FN_SEL0,
    PSS_FN_SEL1,
    PSS_FN_SEL2,
    PSS_FN_SEL3
  } pss_func_t;

  // Read-only status layout
  typedef struct packed {
    logic [1:0] fb_src;
    logic reverse;
    logic avr_on;
    logic pid_on;
    logic [3:0] code;
  } pss_status_t;

endpackage : pss_pkg

// >>> verif/pss_terminal_model.sv
`timescale 1ns/1ns
module pss_terminal_model
(
  input wire logic clk,
  output logic [4:0] digital_in,
  output logic motor_decel,
  output logic [15:0] analog_current_input,
  output logic [15:0] analog_voltage_input
);
  int pos [4] = '{0, 1, 2, 3};
  int nb = 4;
  logic [3:0] code = 4'h0;
  logic tog = 1'b0;
  initial
  begin
    motor_decel = 1'b0;
    analog_current_input = 16'h0000;
    analog_voltage_input = 16'h0000;
  end
  always_ff @(posedge clk) tog <= ~tog;
  // Unwired inputs wander
  always_comb
  begin
    digital_in = {5{tog}};
    for (int k = 0; k < nb; k++)
      digital_in[pos[k]] = code[k];
  end
  // Setpoint comes only as a code, analogue lines carry feedback
  task set(input logic [3:0] c, input logic d, input logic [15:0] i, input logic [15:0] v);
    @(posedge clk);
    code <= c;
    motor_decel <= d;
    analog_current_input <= i;
    analog_voltage_input <= v;
  endtask : set
endmodule : pss_terminal_model

// >>> verif/test_pss_selector.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_pss_selector
  import pss_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [4:0] digital_in;
  logic motor_decel, pid_active, avr_enable, freq_raise, freq_lower;
  logic [15:0] cur, volt, active_setpoint, process_feedback;
  int errors = 0, num_checks = 0, seed = 39;
  int sp [16];
  int spz, spm, pid, avr, fbs, base, lo, hi, cd, dec, c, s, n;

  pss_selector #(.SP_W(16), .NUM_IN(5)) dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digital_in(digital_in), .motor_decel(motor_decel),
    .analog_current_input(cur), .analog_voltage_input(volt),
    .active_setpoint(active_setpoint), .process_feedback(process_feedback),
    .pid_active(pid_active), .avr_enable(avr_enable), .freq_raise(freq_raise),
    .freq_lower(freq_lower));
  pss_terminal_model term (.clk(clk), .digital_in(digital_in), .motor_decel(motor_decel),
    .analog_current_input(cur), .analog_voltage_input(volt));

  initial forever #25 clk = ~clk;

  // ****************************************
  // Bus and model tasks
  // ****************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 10);
    // Answer taken and request released at the edge that sees pready
    rd = prdata;
    er = pslverr;
    `CHK("pready", 1'b1, pready)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd)
    `CHK("pslverr", ee, er)
  endtask : rchk

  task ctrl(input int p, input int v, input int f, input int b);
    pid = p;
    avr = v;
    fbs = f;
    base = b;
    apb(1'b1, 8'h00, 32'((b << 6) | (f << 4) | (v << 2) | p));
  endtask : ctrl

  task set_map(input int skip, input int nb);
    int k, w;
    k = 0;
    w = 0;
    for (int i = 0; i < 5; i++)
      if (i != skip && k < nb)
      begin
        w |= (k + 1) << (3 * i);
        term.pos[k] <= i;
        k++;
      end
    term.nb <= nb;
    apb(1'b1, 8'h04, 32'(w));
    rchk(8'h04, 32'(w), 1'b0);
  endtask : set_map

  task drive(input int cc, input int d);
    int i, v;
    cd = cc;
    dec = d;
    i = $random(seed) & 16'hffff;
    v = $random(seed) & 16'hffff;
    if (($random(seed) & 3) == 0) i = cc == 0 ? (base ? spm : spz) : sp[cc];
    term.set(4'(cc), d[0], 16'(i), 16'(v));
  endtask : drive

  task check_all;
    int e, f, a, rv;
    repeat (4) @(posedge clk);
    @(negedge clk);
    e = cd == 0 ? (base ? spm : spz) : sp[cd];
    f = fbs == 1 ? volt : cur;
    rv = lo == 100 && hi == 0;
    a = !(avr == 1 || (avr == 2 && dec));
    `CHK("setpoint", e[15:0], active_setpoint)
    `CHK("feedback", f[15:0], process_feedback)
    `CHK("pid", pid == 1, pid_active)
    `CHK("avr", a[0], avr_enable)
    `CHK("raise", pid == 1 && (rv ? f > e : f < e), freq_raise)
    `CHK("lower", pid == 1 && (rv ? f < e : f > e), freq_lower)
    rchk(8'h18, 32'(e), 1'b0);
    rchk(8'h14, 32'(((fbs & 3) << 7) | (rv << 6) | (a << 5) | ((pid == 1) << 4) | cd), 1'b0);
  endtask : check_all

  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    foreach (sp[i]) sp[i] = 0;
    {spz, spm, pid, fbs, base, lo, cd, dec} = '0;
    avr = 2;
    hi = 100;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h00, 32'h8, 1'b0);
    rchk(8'h04, 32'h0, 1'b0);
    rchk(8'h08, 32'h6400, 1'b0);
    rchk(8'h40, 32'h0, 1'b1);
    apb(1'b1, 8'h14, 32'hffff);
    check_all();
    spz = $random(seed) & 16'hffff;
    spm = $random(seed) & 16'hffff;
    apb(1'b1, 8'h0c, 32'(spz));
    apb(1'b1, 8'h10, 32'(spm));
    for (n = 1; n < 16; n++)
    begin
      sp[n] = $random(seed) & 16'hffff;
      apb(1'b1, 8'(8'h40 + 4 * n), 32'(sp[n]));
    end
    for (s = 0; s < 2; s++)
    begin
      set_map(s * 4, 4);
      lo = 100;
      hi = 1 - s;
      apb(1'b1, 8'h08, 32'((hi << 8) | lo));
      for (c = 0; c < 16; c++)
      begin
        ctrl(1, c & 3, c % 3, s);
        drive(c, (c >> 2) & 1);
        check_all();
      end
    end
    set_map(4, 2);
    for (c = 0; c < 12; c++)
    begin
      ctrl(c % 4, 2, c & 1, c & 1);
      drive($random(seed) & 3, c & 1);
      check_all();
    end
    results();
  end

  initial
  begin
    #3000000;
    errors++;
    results();
  end
endmodule : test_pss_selector
